// ===== design/step_io_pkg.sv
// shared constants and types for the stepper i/o control ends
package step_io_pkg;
    // ---------------------------------------------------------------
    // operating data and positions
    // ---------------------------------------------------------------
    localparam int unsigned DATA_SEL_W = 6;
    localparam int unsigned POS_W = 32;
    localparam int unsigned ENTRY_COUNT = 64;
    localparam int unsigned SPEED_W = 16;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned READY_DELAY_US = 10;
    localparam int unsigned READY_DELAY_CYC = READY_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned STEP_HIGH_CYC = 2;
    localparam int unsigned RAMP_STEP_CYC = 4;
    // ---------------------------------------------------------------
    // excitation sequence: one zero per 10 full steps
    // ---------------------------------------------------------------
    localparam int unsigned PHASE_STEPS_PER_CYCLE = 10;
    localparam logic [3:0] MICROSTEP_RESET = 4'h1;
    // ---------------------------------------------------------------
    // configuration reset values
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        STOP_IMMEDIATE,
        STOP_DECEL,
        STOP_IMMEDIATE_RELEASE,
        STOP_DECEL_RELEASE
    } stop_action_type;
    localparam stop_action_type STOP_ACTION_RESET = STOP_DECEL;
    typedef enum logic [2:0] {
        SEL_ZONE,
        SEL_READY,
        SEL_WARNING,
        SEL_ORIGIN_FOUND,
        SEL_EXCITATION_PHASE,
        SEL_ENCODER_INDEX,
        SEL_DEVIATION,
        SEL_REMOTE
    } out_select_type;
    localparam logic STOP_NC_RESET = 1'b1;
    localparam logic RELEASE_NC_RESET = 1'b0;
    localparam logic ORIGIN_NC_RESET = 1'b0;
    localparam logic LIMIT_NC_RESET = 1'b0;
    localparam logic SHARED_IS_LOAD_RESET = 1'b0;
    // ---------------------------------------------------------------
    // alarm causes (the led blinks at one fixed rate for every cause)
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ALARM_NONE,
        ALARM_OVERTRAVEL,
        ALARM_DEVIATION,
        ALARM_OVERVOLTAGE,
        ALARM_COMM,
        ALARM_MEMORY
    } alarm_cause_type;
endpackage

// ===== design/step_io_if.sv
// discrete i/o lines between host controller and stepper driver
`timescale 1ns/1ns
interface step_io_if;
    logic start;
    logic stop_line;
    logic winding_release_input;
    logic fault_clear_input;
    logic [step_io_pkg::DATA_SEL_W-1:0] data_select_bits;
    logic plus_jog_input;
    logic minus_jog_input;
    logic origin_or_load;
    logic motion_active;
    logic fault_output;
    logic [3:0] assignable_outputs;
    logic step_pulse_output;
    logic heading;

    modport driver (
        input start, stop_line, winding_release_input, fault_clear_input,
        input data_select_bits, plus_jog_input, minus_jog_input, origin_or_load,
        output motion_active, fault_output, assignable_outputs,
        output step_pulse_output, heading
    );
    modport host (
        output start, stop_line, winding_release_input, fault_clear_input,
        output data_select_bits, plus_jog_input, minus_jog_input, origin_or_load,
        input motion_active, fault_output, assignable_outputs,
        input step_pulse_output, heading
    );
endinterface

// ===== design/pin_sync.sv
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ns
module pin_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } state_type;
    state_type s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.meta = d_i;
        s_d.sync = s_q.meta;
        if (!rstn_i) begin
            s_d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    assign q_o = s_q.sync;
endmodule

// ===== design/step_driver.sv
// driver end: discrete i/o control of the microstep driver
//
// Overview of operation
// - start rising edge launches positioning move
// - four selectable stop actions, decel default
// - stop polarity selectable; run state permits motion
// - winding release cuts current while active
// - fault clear clears alarms except latched ones
// - six select bits choose operating entry
// - jog inputs run continuously plus or minus
// - shared input: origin seek or position load
// - position load copies command position to preset
// - origin sensor ends seek; selectable polarities
// - seek reverses away from detected limit
// - limit during move raises overtravel alarm
// - motion active during any motor operation
// - four outputs mapped to selectable signals
// - zone asserted between two boundaries
// - ready after start-up with stop run
// - origin found after seek completes
// - excitation phase on at step zero
// - encoder index output pulses one cycle on index input rising edge
// - deviation output at encoder difference limit
// - alarm drops fault output, blinks, stops
// - step pulse and heading mirror internal commands
`timescale 1ns/1ns
module step_driver #(
    parameter int unsigned READY_DELAY = step_io_pkg::READY_DELAY_CYC,
    parameter int unsigned DEV_LIMIT = 100
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    step_io_if.driver io,
    input wire logic origin_sensor_i,
    input wire logic plus_travel_limit_i,
    input wire logic minus_travel_limit_i,
    input wire logic encoder_index_phase_input_i,
    input wire logic signed [step_io_pkg::POS_W-1:0] encoder_count_i,
    input wire logic [step_io_pkg::SPEED_W-1:0] entry_speed_i,
    input wire logic signed [step_io_pkg::POS_W-1:0] entry_travel_i,
    input wire step_io_pkg::stop_action_type stop_action_i,
    input wire logic stop_nc_i,
    input wire logic release_nc_i,
    input wire logic origin_nc_i,
    input wire logic limit_nc_i,
    input wire logic shared_is_load_i,
    input wire logic [3:0] microsteps_i,
    input wire logic signed [step_io_pkg::POS_W-1:0] zone_low_i,
    input wire logic signed [step_io_pkg::POS_W-1:0] zone_high_i,
    input wire logic [3:0][2:0] out_select_i,
    input wire logic warning_i,
    input wire logic remote_general_output_i,
    input wire logic overvoltage_i,
    input wire logic comm_error_i,
    input wire logic memory_error_i,
    output logic [step_io_pkg::DATA_SEL_W-1:0] entry_index_o,
    output logic winding_energised_o,
    output logic signed [step_io_pkg::POS_W-1:0] preset_position_o,
    output logic signed [step_io_pkg::POS_W-1:0] command_position_o,
    output step_io_pkg::alarm_cause_type alarm_cause_o,
    output logic alarm_led_o
);
    localparam int unsigned PW = step_io_pkg::POS_W;
    typedef enum logic [2:0] {IDLE, MOVE, JOG_P, JOG_N, SEEK, DECEL} mode_type;
    typedef struct packed {
        logic [31:0] ready_cnt;
        logic ready;
        mode_type mode;
        logic dir;
        logic [PW-1:0] remaining;
        logic [step_io_pkg::SPEED_W-1:0] div_cnt;
        logic [7:0] ramp;
        logic step;
        logic signed [PW-1:0] cmd_pos;
        logic signed [PW-1:0] preset;
        logic [7:0] phase_cnt;
        logic energised;
        logic release_after;
        logic origin_found;
        step_io_pkg::alarm_cause_type cause;
        logic [25:0] blink_cnt;
        logic led;
        logic start_prev;
        logic shared_prev;
        logic idx_prev;
        logic index_flag;
        logic [3:0] outs;
        logic fault_n;
        logic moving;
    } state_type;
    state_type s_q, s_d;

    logic [10:0] pins;
    logic [10:0] pins_s;
    assign pins = {io.start, io.stop_line, io.winding_release_input, io.fault_clear_input,
                   io.plus_jog_input, io.minus_jog_input, io.origin_or_load,
                   origin_sensor_i, plus_travel_limit_i, minus_travel_limit_i,
                   encoder_index_phase_input_i};
    logic [5:0] sel_s;

    pin_sync #(.W(11)) u_sync (
        .clk_i(clk_i), .rstn_i(rstn_i), .d_i(pins), .q_o(pins_s)
    );
    pin_sync #(.W(6)) u_sync_sel (
        .clk_i(clk_i), .rstn_i(rstn_i), .d_i(io.data_select_bits), .q_o(sel_s)
    );

    logic run_ok, release_on, origin_hit, plim, nlim, start_rise, shared_rise;
    logic any_lim, step_tick, phase_zero, zone, deviation;
    logic signed [PW-1:0] dev;
    logic [7:0] ph_period;

    always_comb begin
        run_ok = stop_nc_i ? pins_s[9] : !pins_s[9];
        release_on = pins_s[8] ^ release_nc_i;
        origin_hit = pins_s[3] ^ origin_nc_i;
        plim = pins_s[2] ^ limit_nc_i;
        nlim = pins_s[1] ^ limit_nc_i;
        any_lim = plim | nlim;
        start_rise = pins_s[10] & !s_q.start_prev;
        shared_rise = pins_s[4] & !s_q.shared_prev;
        step_tick = (s_q.div_cnt == '0) && (s_q.mode != IDLE);
        ph_period = 8'(step_io_pkg::PHASE_STEPS_PER_CYCLE * microsteps_i);
        phase_zero = (s_q.phase_cnt == 8'h00);
        zone = (s_q.cmd_pos >= zone_low_i) && (s_q.cmd_pos <= zone_high_i);
        dev = encoder_count_i - s_q.cmd_pos;
        deviation = ((dev < 0) ? -dev : dev) >= PW'(DEV_LIMIT);
    end

    function automatic logic pick(input logic [2:0] sel, input logic [7:0] src);
        pick = src[sel];
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.start_prev = pins_s[10];
        s_d.shared_prev = pins_s[4];
        s_d.idx_prev = pins_s[0];
        s_d.step = 1'b0;
        s_d.index_flag = pins_s[0] & !s_q.idx_prev;
        // ready after start-up delay with stop in run state
        if (s_q.ready_cnt != READY_DELAY) begin
            s_d.ready_cnt = s_q.ready_cnt + 32'h1;
        end
        s_d.ready = (s_q.ready_cnt == READY_DELAY) && run_ok
                    && (s_q.cause == step_io_pkg::ALARM_NONE);
        // step rate divider
        if (s_q.mode != IDLE) begin
            s_d.div_cnt = (s_q.div_cnt == '0) ? entry_speed_i : s_q.div_cnt - 1'b1;
        end
        if (step_tick) begin
            s_d.step = 1'b1;
            s_d.cmd_pos = s_q.dir ? s_q.cmd_pos + 1 : s_q.cmd_pos - 1;
            s_d.phase_cnt = (s_q.phase_cnt + 8'h01 >= ph_period) ? 8'h00
                            : s_q.phase_cnt + 8'h01;
            if (s_q.remaining != '0) begin
                s_d.remaining = s_q.remaining - 1'b1;
            end
            if (s_q.ramp != '0) begin
                s_d.ramp = s_q.ramp - 8'h01;
            end
        end
        case (s_q.mode)
            IDLE: begin
                s_d.div_cnt = '0;
                if (s_q.ready && s_q.energised) begin
                    if (start_rise) begin
                        s_d.mode = MOVE;
                        s_d.dir = !entry_travel_i[PW-1];
                        s_d.remaining = entry_travel_i[PW-1] ? -entry_travel_i : entry_travel_i;
                    end else if (pins_s[6]) begin
                        s_d.mode = JOG_P;
                        s_d.dir = 1'b1;
                    end else if (pins_s[5]) begin
                        s_d.mode = JOG_N;
                        s_d.dir = 1'b0;
                    end else if (shared_rise && !shared_is_load_i) begin
                        s_d.mode = SEEK;
                        s_d.dir = 1'b0;
                        s_d.origin_found = 1'b0;
                    end
                end
            end
            MOVE: begin
                if (s_q.remaining == '0 || (step_tick && s_q.remaining == 1)) begin
                    s_d.mode = IDLE;
                end
            end
            JOG_P: if (!pins_s[6]) s_d.mode = IDLE;
            JOG_N: if (!pins_s[5]) s_d.mode = IDLE;
            SEEK: begin
                if (origin_hit) begin
                    s_d.mode = IDLE;
                    s_d.origin_found = 1'b1;
                end else if (plim) begin
                    s_d.dir = 1'b0;
                end else if (nlim) begin
                    s_d.dir = 1'b1;
                end
            end
            DECEL: if (s_q.ramp == '0) s_d.mode = IDLE;
            default: s_d.mode = IDLE;
        endcase
        // stop request, overtravel and alarms
        if (s_q.mode != IDLE && !run_ok) begin
            s_d.release_after = stop_action_i[1];
            if (stop_action_i == step_io_pkg::STOP_DECEL
                || stop_action_i == step_io_pkg::STOP_DECEL_RELEASE) begin
                if (s_q.mode != DECEL) begin
                    s_d.mode = DECEL;
                    s_d.ramp = 8'(step_io_pkg::RAMP_STEP_CYC);
                end
            end else begin
                s_d.mode = IDLE;
            end
        end
        if (s_q.release_after && s_q.mode == IDLE) begin
            s_d.energised = 1'b0;
            s_d.release_after = 1'b0;
        end
        if (s_q.mode != IDLE && s_q.mode != SEEK && any_lim
            && s_q.cause == step_io_pkg::ALARM_NONE) begin
            s_d.cause = step_io_pkg::ALARM_OVERTRAVEL;
        end
        if (s_q.mode != IDLE && deviation && s_q.cause == step_io_pkg::ALARM_NONE) begin
            s_d.cause = step_io_pkg::ALARM_DEVIATION;
        end
        if (shared_rise && shared_is_load_i) begin
            s_d.preset = s_q.cmd_pos;
        end
        if (pins_s[7] && s_q.cause != step_io_pkg::ALARM_OVERVOLTAGE
            && s_q.cause != step_io_pkg::ALARM_COMM
            && s_q.cause != step_io_pkg::ALARM_MEMORY && !any_lim) begin
            s_d.cause = step_io_pkg::ALARM_NONE;
        end
        if (overvoltage_i) s_d.cause = step_io_pkg::ALARM_OVERVOLTAGE;
        if (comm_error_i) s_d.cause = step_io_pkg::ALARM_COMM;
        if (memory_error_i) s_d.cause = step_io_pkg::ALARM_MEMORY;
        if (s_d.cause != step_io_pkg::ALARM_NONE) begin
            s_d.mode = IDLE;
        end
        if (release_on) begin
            s_d.energised = 1'b0;
            s_d.mode = IDLE;
        end else if (!s_q.release_after && s_q.cause == step_io_pkg::ALARM_NONE
                     && !(s_q.mode == IDLE && !s_q.energised && !run_ok)) begin
            s_d.energised = 1'b1;
        end
        // alarm indicator blink
        s_d.blink_cnt = s_q.blink_cnt + 26'h1;
        s_d.led = (s_q.cause != step_io_pkg::ALARM_NONE) && s_q.blink_cnt[25];
        s_d.fault_n = (s_d.cause == step_io_pkg::ALARM_NONE);
        s_d.moving = (s_d.mode != IDLE) || s_d.step;
        for (int i = 0; i < 4; i++) begin
            s_d.outs[i] = pick(out_select_i[i], {remote_general_output_i, deviation,
                          s_q.index_flag, phase_zero, s_q.origin_found, warning_i,
                          s_q.ready, zone});
        end
        if (!rstn_i) begin
            s_d = '0;
            s_d.mode = IDLE;
            s_d.energised = 1'b1;
            s_d.cause = step_io_pkg::ALARM_NONE;
            s_d.phase_cnt = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    assign io.motion_active = s_q.moving;
    assign io.fault_output = s_q.fault_n;
    assign io.assignable_outputs = s_q.outs;
    assign io.step_pulse_output = s_q.step;
    assign io.heading = s_q.dir;
    assign entry_index_o = sel_s;
    assign winding_energised_o = s_q.energised;
    assign preset_position_o = s_q.preset;
    assign command_position_o = s_q.cmd_pos;
    assign alarm_cause_o = s_q.cause;
    assign alarm_led_o = s_q.led;
endmodule

// ===== design/step_host.sv
// host end: drives the discrete command lines of the driver
`timescale 1ns/1ns
module step_host (
    input wire logic clk_i,
    input wire logic rstn_i,
    step_io_if.host io,
    input wire logic move_req_i,
    input wire logic run_i,
    input wire logic release_i,
    input wire logic clear_i,
    input wire logic [step_io_pkg::DATA_SEL_W-1:0] entry_i,
    input wire logic jog_plus_i,
    input wire logic jog_minus_i,
    input wire logic shared_i,
    output logic ready_o,
    output logic fault_seen_o,
    output logic busy_o
);
    typedef struct packed {
        logic start;
        logic stop_line;
        logic rel;
        logic clr;
        logic [step_io_pkg::DATA_SEL_W-1:0] sel;
        logic jp;
        logic jn;
        logic shared;
        logic ready;
        logic fault;
        logic busy;
    } state_type;
    state_type s_q, s_d;
    logic [3:0] back_s;
    logic ok;

    pin_sync #(.W(4)) u_sync (
        .clk_i(clk_i), .rstn_i(rstn_i),
        .d_i({io.assignable_outputs[1], io.fault_output, io.motion_active, 1'b0}),
        .q_o(back_s)
    );

    always_comb begin
        s_d = s_q;
        ok = back_s[3] && back_s[2];
        s_d.ready = back_s[3];
        s_d.fault = !back_s[2];
        s_d.busy = back_s[1];
        s_d.stop_line = run_i;
        s_d.rel = release_i;
        s_d.clr = clear_i;
        s_d.sel = entry_i;
        s_d.start = move_req_i && ok && !back_s[1];
        s_d.jp = jog_plus_i && ok;
        s_d.jn = jog_minus_i && ok && !jog_plus_i;
        s_d.shared = shared_i && ok;
        if (!rstn_i) begin
            s_d = '0;
            s_d.stop_line = step_io_pkg::STOP_NC_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    assign io.start = s_q.start;
    assign io.stop_line = s_q.stop_line;
    assign io.winding_release_input = s_q.rel;
    assign io.fault_clear_input = s_q.clr;
    assign io.data_select_bits = s_q.sel;
    assign io.plus_jog_input = s_q.jp;
    assign io.minus_jog_input = s_q.jn;
    assign io.origin_or_load = s_q.shared;
    assign ready_o = s_q.ready;
    assign fault_seen_o = s_q.fault;
    assign busy_o = s_q.busy;
endmodule

// ===== tb/step_io_chk.sv
// concurrent checks on the discrete lines between host and driver
`timescale 1ns/1ns
module step_io_chk (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start,
    input wire logic stop_line,
    input wire logic winding_release_input,
    input wire logic plus_jog_input,
    input wire logic minus_jog_input,
    input wire logic motion_active,
    input wire logic fault_output,
    input wire logic [3:0] assignable_outputs,
    input wire logic step_pulse_output,
    input wire logic heading
);
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    logic [5:0] stop_cnt_q;
    always_ff @(posedge clk_i) begin
        if (!rstn_i || stop_line) begin
            stop_cnt_q <= 6'h00;
        end else if (stop_cnt_q != 6'h3f) begin
            stop_cnt_q <= stop_cnt_q + 6'h01;
        end
    end
    sequence s_idle_ok;
        assignable_outputs[1] && fault_output && stop_line && !winding_release_input
            && !motion_active;
    endsequence
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    property p_start_launch;
        $rose(start) ##0 s_idle_ok |-> ##[1:8] motion_active;
    endproperty
    a_start_launch: assert property (p_start_launch) else $error("start edge ignored");
    property p_jog_plus;
        $rose(plus_jog_input) ##0 s_idle_ok |-> ##[1:8] (motion_active && heading);
    endproperty
    a_jog_plus: assert property (p_jog_plus) else $error("plus jog did not run");
    property p_jog_minus;
        $rose(minus_jog_input) ##0 s_idle_ok |-> ##[1:8] (motion_active && !heading);
    endproperty
    a_jog_minus: assert property (p_jog_minus) else $error("minus jog did not run");
    property p_step_single;
        step_pulse_output |=> !step_pulse_output;
    endproperty
    a_step_single: assert property (p_step_single) else $error("step pulse too long");
    property p_step_moving;
        step_pulse_output |-> motion_active;
    endproperty
    a_step_moving: assert property (p_step_moving) else $error("step while idle");
    property p_ready_first;
        $rose(motion_active) |-> $past(assignable_outputs[1]);
    endproperty
    a_ready_first: assert property (p_ready_first) else $error("move without ready");
    property p_alarm_stop;
        $fell(fault_output) |-> ##[0:6] !motion_active;
    endproperty
    a_alarm_stop: assert property (p_alarm_stop) else $error("alarm did not stop");
    property p_stop_halt;
        stop_cnt_q == 6'h3c |-> !motion_active;
    endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("moving with stop held");
endmodule

// ===== tb/tb_top.sv
// self-checking bench: host end and driver end joined by the i/o lines
`timescale 1ns/1ns
module tb_top;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic move_req = 1'b0, run = 1'b1, rel = 1'b0, clr = 1'b0, jog_p = 1'b0, jog_m = 1'b0;
    logic shared = 1'b0, load_mode = 1'b0, rel_nc = 1'b0, lim_nc = 1'b0, org = 1'b0;
    logic lim_p = 1'b0, lim_m = 1'b0, idx = 1'b0, warn = 1'b0, remote = 1'b0;
    logic ovv = 1'b0, comm = 1'b0, mem = 1'b0, energised;
    logic [5:0] entry = 6'h00;
    logic [5:0] entry_idx;
    logic [15:0] speed = 16'h0003;
    logic signed [31:0] travel = 32'sh5, zlo = 32'sh0, zhi = 32'sha, preset, cmd_pos;
    logic [3:0][2:0] out_sel = {3'h3, 3'h2, 3'h1, 3'h0};
    step_io_pkg::alarm_cause_type cause;
    int error_cnt = 0, n_tests = 0, n, k;
    logic signed [31:0] exp_pos;
    step_io_if io ();
    step_driver #(.READY_DELAY(5)) step_driver_i (.clk_i(clk_i), .rstn_i(rstn_i), .io(io),
        .origin_sensor_i(org), .plus_travel_limit_i(lim_p), .minus_travel_limit_i(lim_m),
        .encoder_index_phase_input_i(idx), .encoder_count_i(32'sh0), .entry_speed_i(speed),
        .entry_travel_i(travel), .stop_action_i(step_io_pkg::STOP_ACTION_RESET),
        .stop_nc_i(1'b1), .release_nc_i(rel_nc), .origin_nc_i(1'b0), .limit_nc_i(lim_nc),
        .shared_is_load_i(load_mode), .microsteps_i(4'h1), .zone_low_i(zlo), .zone_high_i(zhi),
        .out_select_i(out_sel), .warning_i(warn), .remote_general_output_i(remote),
        .overvoltage_i(ovv), .comm_error_i(comm), .memory_error_i(mem),
        .entry_index_o(entry_idx), .winding_energised_o(energised), .preset_position_o(preset),
        .command_position_o(cmd_pos), .alarm_cause_o(cause), .alarm_led_o());
    step_host step_host_i (.clk_i(clk_i), .rstn_i(rstn_i), .io(io), .move_req_i(move_req),
        .run_i(run), .release_i(rel), .clear_i(clr), .entry_i(entry), .jog_plus_i(jog_p),
        .jog_minus_i(jog_m), .shared_i(shared), .ready_o(), .fault_seen_o(), .busy_o());
    step_io_chk step_io_chk_i (.clk_i(clk_i), .rstn_i(rstn_i), .start(io.start),
        .stop_line(io.stop_line), .winding_release_input(io.winding_release_input),
        .plus_jog_input(io.plus_jog_input), .minus_jog_input(io.minus_jog_input),
        .motion_active(io.motion_active), .fault_output(io.fault_output),
        .assignable_outputs(io.assignable_outputs), .step_pulse_output(io.step_pulse_output),
        .heading(io.heading));
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask
    task chk_pos(input logic signed [31:0] got, input logic signed [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t value got %0d expected %0d", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task step(input int c);
        repeat (c) @(negedge clk_i);
    endtask
    task wait_ready;
        for (k = 0; k < 200 && io.assignable_outputs[1] !== 1'b1; k++) @(negedge clk_i);
        chk_bit(io.assignable_outputs[1], 1'b1);
    endtask
    task wait_fault(input logic v);
        for (k = 0; k < 100 && io.fault_output !== v; k++) @(negedge clk_i);
        chk_bit(io.fault_output, v);
    endtask
    task run_count(input logic dir, output int cnt);
        cnt = 0;
        for (k = 0; k < 100 && io.motion_active !== 1'b1; k++) @(negedge clk_i);
        chk_bit(io.motion_active, 1'b1);
        chk_bit(io.heading, dir);
        for (k = 0; k < 3000 && io.motion_active === 1'b1; k++) begin
            if (io.step_pulse_output === 1'b1) cnt++;
            @(negedge clk_i);
        end
    endtask
    // ------------------------------------------------
    // clock, watchdog and tests
    // ------------------------------------------------
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #300000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        @(negedge clk_i) rstn_i = 1'b1;
        wait_ready();
        chk_bit(io.fault_output, 1'b1);
        chk_bit(energised, 1'b1);
        entry = 6'h2a;
        step(8);
        chk_pos({26'h0, entry_idx}, 32'sh2a);
        move_req = 1'b1;
        run_count(1'b1, n);
        move_req = 1'b0;
        chk_pos(32'(n), 32'sh5);
        chk_pos(cmd_pos, 32'sh5);
        step(4);
        chk_bit(io.assignable_outputs[0], 1'b1);
        zhi = 32'sh3;
        step(6);
        chk_bit(io.assignable_outputs[0], 1'b0);
        jog_m = 1'b1;
        fork
            run_count(1'b0, n);
            begin
                step(30);
                run = 1'b0;
            end
        join
        exp_pos = 32'sh5 - 32'(n);
        chk_pos(cmd_pos, exp_pos);
        step(70);
        chk_bit(io.motion_active, 1'b0);
        jog_m = 1'b0;
        run = 1'b1;
        wait_ready();
        jog_p = 1'b1;
        fork
            run_count(1'b1, n);
            begin
                step(20);
                jog_p = 1'b0;
            end
        join
        exp_pos = exp_pos + 32'(n);
        chk_pos(cmd_pos, exp_pos);
        load_mode = 1'b1;
        shared = 1'b1;
        step(8);
        chk_pos(preset, exp_pos);
        shared = 1'b0;
        rel = 1'b1;
        step(8);
        chk_bit(energised, 1'b0);
        rel = 1'b0;
        step(8);
        chk_bit(energised, 1'b1);
        rel_nc = 1'b1;
        step(8);
        chk_bit(energised, 1'b0);
        rel_nc = 1'b0;
        warn = 1'b1;
        remote = 1'b1;
        out_sel[0] = 3'h7;
        step(8);
        chk_bit(io.assignable_outputs[2], 1'b1);
        chk_bit(io.assignable_outputs[0], 1'b1);
        load_mode = 1'b0;
        shared = 1'b1;
        fork
            run_count(1'b0, n);
            begin
                step(12);
                lim_m = 1'b1;
                step(6);
                chk_bit(io.heading, 1'b1);
                lim_m = 1'b0;
                org = 1'b1;
            end
        join
        shared = 1'b0;
        org = 1'b0;
        step(4);
        chk_bit(io.assignable_outputs[3], 1'b1);
        travel = 32'sh3e8;
        wait_ready();
        move_req = 1'b1;
        step(12);
        lim_p = 1'b1;
        wait_fault(1'b0);
        chk_pos(32'(cause), 32'(step_io_pkg::ALARM_OVERTRAVEL));
        step(8);
        chk_bit(io.motion_active, 1'b0);
        move_req = 1'b0;
        lim_p = 1'b0;
        clr = 1'b1;
        step(4);
        clr = 1'b0;
        wait_fault(1'b1);
        ovv = 1'b1;
        wait_fault(1'b0);
        ovv = 1'b0;
        clr = 1'b1;
        step(4);
        clr = 1'b0;
        step(30);
        chk_bit(io.fault_output, 1'b0);
        end_of_test();
    end
endmodule
